// ---- common/pfc_defs.vh ----
/*
 * Register offsets, field layouts, reset values and timing counts for the
 * PFC switching frequency and voltage loop configuration block.
 * Assumes a 10 MHz core clock and 16-bit register addresses.
 */
`ifndef PFC_DEFS_VH
`define PFC_DEFS_VH

`define ADDR_W               16
`define OFS_DITHER_PERIOD    16'hfe1d
`define OFS_SYNC_DIVIDER     16'hfe1e
`define OFS_LOOP_GAIN        16'hfe20
`define OFS_LOOP_ZERO        16'hfe21
`define OFS_FAST_GAIN        16'hfe22

`define DITHER_FIELD_MSB     6
`define SYNC_DIV_MSB         1
`define RST_DITHER_PERIOD    7'h00
`define RST_SYNC_DIVIDER     8'h00
`define RST_LOOP_GAIN        8'h00
`define RST_LOOP_ZERO        8'h00
`define RST_FAST_GAIN        8'h00

`define CLK_FREQ_KHZ         10000
`define DITHER_STEP_US       40
`define DITHER_STEP_CYCLES   ((`DITHER_STEP_US * `CLK_FREQ_KHZ) / 1000)

`define PERIOD_W             9
`define NOMINAL_PERIOD       9'h064
`define DITHER_SPAN          4'h4

`endif

// ---- rtl/freq_code_rom.v ----
/*
 * Lookup of the 6-bit low-power frequency code to a switching period in
 * core clock cycles; read data come out of a register.
 * Assumes a 10 MHz clock; each entry is 10000 / f(kHz), rounded.
 */
`default_nettype none
module freq_code_rom (
	input  wire       core_clk,
	input  wire       rst_n,
	input  wire [5:0] code,
	output reg  [8:0] period
);
	reg [8:0] lookup;

	always @* begin
		case (code)
		6'h00: lookup = 9'd333;  6'h01: lookup = 9'd307;  6'h02: lookup = 9'd282;
		6'h03: lookup = 9'd256;  6'h04: lookup = 9'd230;  6'h05: lookup = 9'd205;
		6'h06: lookup = 9'd192;  6'h07: lookup = 9'd179;  6'h08: lookup = 9'd166;
		6'h09: lookup = 9'd154;  6'h0a: lookup = 9'd141;  6'h0b: lookup = 9'd128;
		6'h0c: lookup = 9'd115;  6'h0d: lookup = 9'd102;  6'h0e: lookup = 9'd99;
		6'h0f: lookup = 9'd96;   6'h10: lookup = 9'd93;   6'h11: lookup = 9'd90;
		6'h12: lookup = 9'd86;   6'h13: lookup = 9'd83;   6'h14: lookup = 9'd80;
		6'h15: lookup = 9'd77;   6'h16: lookup = 9'd74;   6'h17: lookup = 9'd70;
		6'h18: lookup = 9'd67;   6'h19: lookup = 9'd64;   6'h1a: lookup = 9'd61;
		6'h1b: lookup = 9'd58;   6'h1c: lookup = 9'd54;   6'h1d: lookup = 9'd51;
		6'h1e: lookup = 9'd50;   6'h1f: lookup = 9'd50;   6'h20: lookup = 9'd49;
		6'h21: lookup = 9'd48;   6'h22: lookup = 9'd47;   6'h23: lookup = 9'd46;
		6'h24: lookup = 9'd46;   6'h25: lookup = 9'd45;   6'h26: lookup = 9'd44;
		6'h27: lookup = 9'd43;   6'h28: lookup = 9'd42;   6'h29: lookup = 9'd42;
		6'h2a: lookup = 9'd41;   6'h2b: lookup = 9'd40;   6'h2c: lookup = 9'd39;
		6'h2d: lookup = 9'd38;   6'h2e: lookup = 9'd38;   6'h2f: lookup = 9'd37;
		6'h30: lookup = 9'd36;   6'h31: lookup = 9'd35;   6'h32: lookup = 9'd34;
		6'h33: lookup = 9'd34;   6'h34: lookup = 9'd33;   6'h35: lookup = 9'd32;
		6'h36: lookup = 9'd31;   6'h37: lookup = 9'd30;   6'h38: lookup = 9'd30;
		6'h39: lookup = 9'd29;   6'h3a: lookup = 9'd28;   6'h3b: lookup = 9'd27;
		6'h3c: lookup = 9'd26;   6'h3d: lookup = 9'd26;   6'h3e: lookup = 9'd25;
		default: lookup = 9'd25;
		endcase
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			period <= 9'd0;
		else
			period <= lookup;
	end
endmodule
`default_nettype wire

// ---- rtl/pfc_switching_freq_loop_config.v ----
/*
 * Switching frequency and voltage loop configuration for a digital PFC
 * controller: register file, dithered switching period, external sync
 * division, low-power frequency code and loop filter settings.
 * Assumes all inputs synchronous to core_clk; the management interface
 * presents a simple one-cycle read/write strobe with a 16-bit address.
 */
`include "pfc_defs.vh"
`default_nettype none
module pfc_switching_freq_loop_config #(
	parameter [`PERIOD_W-1:0] NOMINAL_PERIOD = `NOMINAL_PERIOD,
	parameter [3:0]           DITHER_SPAN    = `DITHER_SPAN
) (
	input  wire               core_clk,
	input  wire               rst_n,
	input  wire [`ADDR_W-1:0] reg_addr,
	input  wire               reg_write,
	input  wire               reg_read,
	input  wire [7:0]         reg_wdata,
	output reg  [7:0]         reg_rdata,
	output reg                reg_hit,
	input  wire               dither_enable,
	input  wire               smart_freq_enable,
	input  wire               low_power,
	input  wire [5:0]         low_power_freq_code,
	input  wire               ext_sync_enable,
	input  wire               sync_in,
	input  wire [7:0]         on_time,
	output reg                switching_frequency,
	output reg                period_start,
	output reg  [7:0]         normal_loop_gain,
	output reg  [7:0]         normal_loop_zero,
	output reg  [7:0]         fast_loop_gain
);
	localparam integer STEP_CYCLES_FULL = `DITHER_STEP_CYCLES;
	localparam [8:0]   STEP_CYCLES      = STEP_CYCLES_FULL[8:0];

	reg  [6:0]           dither_update_period;
	reg  [7:0]           sync_clock_divider;
	reg  [8:0]           step_count;
	reg  [6:0]           step_total;
	reg                  dither_update;
	reg  [3:0]           dither_offset;
	reg                  dither_down;
	reg                  sync_prev;
	reg  [1:0]           sync_edges;
	reg  [`PERIOD_W-1:0] cycle_count;
	reg  [`PERIOD_W-1:0] active_period;
	reg  [`PERIOD_W-1:0] next_period;
	wire [`PERIOD_W-1:0] code_period;
	wire                 sync_edge;
	wire                 sync_fire;
	wire                 free_end;

	freq_code_rom code_rom (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.code     (low_power_freq_code),
		.period   (code_period)
	);

	// register writes; unmapped addresses are ignored
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dither_update_period <= `RST_DITHER_PERIOD;
			sync_clock_divider   <= `RST_SYNC_DIVIDER;
			normal_loop_gain     <= `RST_LOOP_GAIN;
			normal_loop_zero     <= `RST_LOOP_ZERO;
			fast_loop_gain       <= `RST_FAST_GAIN;
		end else if (reg_write) begin
			if (reg_addr == `OFS_DITHER_PERIOD) begin
				dither_update_period <= reg_wdata[`DITHER_FIELD_MSB:0];
			end else if (reg_addr == `OFS_SYNC_DIVIDER) begin
				sync_clock_divider <= reg_wdata;
			end else if (reg_addr == `OFS_LOOP_GAIN) begin
				normal_loop_gain <= reg_wdata;
			end else if (reg_addr == `OFS_LOOP_ZERO) begin
				normal_loop_zero <= reg_wdata;
			end else if (reg_addr == `OFS_FAST_GAIN) begin
				fast_loop_gain <= reg_wdata;
			end
		end
	end

	// registered read data; reserved bit 7 of the dither register reads zero
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
			reg_hit   <= 1'b0;
		end else if (reg_read) begin
			reg_hit <= 1'b1;
			if (reg_addr == `OFS_DITHER_PERIOD) begin
				reg_rdata <= {1'b0, dither_update_period};
			end else if (reg_addr == `OFS_SYNC_DIVIDER) begin
				reg_rdata <= sync_clock_divider;
			end else if (reg_addr == `OFS_LOOP_GAIN) begin
				reg_rdata <= normal_loop_gain;
			end else if (reg_addr == `OFS_LOOP_ZERO) begin
				reg_rdata <= normal_loop_zero;
			end else if (reg_addr == `OFS_FAST_GAIN) begin
				reg_rdata <= fast_loop_gain;
			end else begin
				reg_rdata <= 8'h00;
				reg_hit   <= 1'b0;
			end
		end else begin
			reg_hit <= 1'b0;
		end
	end

	// 40 us tick counter, then count ticks up to the programmed period
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			step_count    <= 9'd0;
			step_total    <= 7'd0;
			dither_update <= 1'b0;
		end else begin
			dither_update <= 1'b0;
			if (!dither_enable || dither_update_period == 7'd0) begin
				step_count <= 9'd0;
				step_total <= 7'd0;
			end else if (step_count == STEP_CYCLES - 9'd1) begin
				step_count <= 9'd0;
				// a field lowered below the running count must not wait for a wrap
				if (step_total >= dither_update_period - 7'd1) begin
					step_total    <= 7'd0;
					dither_update <= 1'b1;
				end else begin
					step_total <= step_total + 7'd1;
				end
			end else begin
				step_count <= step_count + 9'd1;
			end
		end
	end

	// triangular sweep of the period offset, one step per update
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dither_offset <= 4'h0;
			dither_down   <= 1'b0;
		end else if (!dither_enable) begin
			dither_offset <= 4'h0;
			dither_down   <= 1'b0;
		end else if (dither_update) begin
			if (dither_down) begin
				if (dither_offset == 4'h1)
					dither_down <= 1'b0;
				dither_offset <= dither_offset - 4'h1;
			end else begin
				if (dither_offset == DITHER_SPAN - 4'h1)
					dither_down <= 1'b1;
				dither_offset <= dither_offset + 4'h1;
			end
		end
	end

	// base period: frequency code only in smart low-power mode
	always @* begin
		if (smart_freq_enable && low_power)
			next_period = code_period + {5'd0, dither_offset};
		else
			next_period = NOMINAL_PERIOD + {5'd0, dither_offset};
	end

	// external sync: one switching period per (division + 1) sync edges
	assign sync_edge = sync_in && !sync_prev;
	assign sync_fire = sync_edge && (sync_edges == sync_clock_divider[`SYNC_DIV_MSB:0]);
	assign free_end  = (cycle_count >= active_period - 9'd1);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_prev  <= 1'b0;
			sync_edges <= 2'd0;
		end else begin
			sync_prev <= sync_in;
			if (!ext_sync_enable || sync_fire)
				sync_edges <= 2'd0;
			else if (sync_edge)
				sync_edges <= sync_edges + 2'd1;
		end
	end

	// period counter and switch drive; the new period is taken at a boundary
	// so a dither step never truncates a pulse already running
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cycle_count         <= 9'd0;
			active_period       <= NOMINAL_PERIOD;
			period_start        <= 1'b0;
			switching_frequency <= 1'b0;
		end else begin
			period_start <= 1'b0;
			if (ext_sync_enable ? sync_fire : free_end) begin
				cycle_count         <= 9'd0;
				active_period       <= next_period;
				period_start        <= 1'b1;
				switching_frequency <= (on_time != 8'h00);
			end else begin
				if (cycle_count != 9'h1ff)
					cycle_count <= cycle_count + 9'd1;
				if (cycle_count + 9'd1 >= {1'b0, on_time})
					switching_frequency <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verification/pfc_cfg_properties.sv ----
/* port-level properties of the PFC configuration block.
 * assumes one core_clk domain and a bind onto the block's top module. */
`default_nettype none
module pfc_cfg_properties (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic [15:0] reg_addr,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_hit,
	input wire logic        ext_sync_enable,
	input wire logic        sync_in,
	input wire logic        period_start,
	input wire logic [7:0]  normal_loop_gain,
	input wire logic [7:0]  normal_loop_zero,
	input wire logic [7:0]  fast_loop_gain
);
	logic [1:0] div;
	wire        rd     = reg_read && !reg_write;
	wire        mapped = reg_addr inside {16'hfe1d, 16'hfe1e, 16'hfe20, 16'hfe21, 16'hfe22};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// shadow of the division field, only the block's ports are visible here
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			div <= 2'b00;
		else if (reg_write && reg_addr == 16'hfe1e)
			div <= reg_wdata[1:0];
	end
	property p_gain; rd && reg_addr == 16'hfe20 |=> reg_rdata == normal_loop_gain; endproperty
	a_gain: assert property (p_gain) else $error("gain output differs from register");
	property p_zero; rd && reg_addr == 16'hfe21 |=> reg_rdata == normal_loop_zero; endproperty
	a_zero: assert property (p_zero) else $error("zero output differs from register");
	property p_fast; rd && reg_addr == 16'hfe22 |=> reg_rdata == fast_loop_gain; endproperty
	a_fast: assert property (p_fast) else $error("fast gain differs from register");
	property p_hit; reg_read |=> reg_hit == $past(mapped); endproperty
	a_hit: assert property (p_hit) else $error("read hit flag wrong");
	property p_miss; reg_read && !mapped |=> reg_rdata == 8'h00; endproperty
	a_miss: assert property (p_miss) else $error("unmapped read not zero");
	property p_reserved_bits; reg_read && reg_addr == 16'hfe1d |=> !reg_rdata[7]; endproperty
	a_reserved_bits: assert property (p_reserved_bits) else $error("dither bit 7 reads one");
	property p_div1;
		ext_sync_enable && $past(ext_sync_enable) && div == 2'b00 && $rose(sync_in)
			|=> period_start;
	endproperty
	a_div1: assert property (p_div1) else $error("no period start after sync edge");
	property p_sync_only;
		$past(ext_sync_enable) && period_start |-> $past(sync_in) && !$past(sync_in, 2);
	endproperty
	a_sync_only: assert property (p_sync_only) else $error("period start without edge");
endmodule
bind pfc_switching_freq_loop_config pfc_cfg_properties pfc_cfg_properties_inst (.*);
`default_nettype wire

// ---- verification/pfc_sync_source.sv ----
/* external sync source and power-stage probe facing the block.
 * assumes pulses launched 1 ns after core_clk rises. */
`default_nettype none
module pfc_sync_source (
	input  wire logic       core_clk,
	input  wire logic       run,
	input  wire logic [7:0] gap,
	input  wire logic       switching_frequency,
	output var  logic       sync_in,
	output var  int         on_width
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	int hi = 0;
	initial sync_in = 1'b0;
	initial on_width = 0;
	// one-cycle pulses keep the pin low between edges; idles low when stopped
	always @(posedge core_clk) begin
		cnt = (run && cnt + 1 < gap) ? cnt + 1 : 0;
		sync_in <= #1 run && cnt == 0;
	end
	// sampled mid-cycle so the drive output has settled
	always @(negedge core_clk) begin
		if (switching_frequency)
			hi++;
		else if (hi > 0) begin
			on_width = hi;
			hi = 0;
		end
	end
endmodule
`default_nettype wire

// ---- verification/test_pfc_switching_freq_loop_config.sv ----
/* self-checking bench for the PFC configuration block.
 * assumes default parameters and a 10 MHz core_clk. */
`default_nettype none
module test_pfc_switching_freq_loop_config;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 0, rst_n = 0, reg_write = 0, reg_read = 0, run = 0;
	logic        dither_enable = 0, smart_freq_enable = 0, low_power = 0, ext_sync_enable = 0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0]  reg_wdata = 8'h00, on_time = 8'h05, gap = 8'h14;
	logic [5:0]  low_power_freq_code = 6'h00;
	logic [7:0]  reg_rdata, normal_loop_gain, normal_loop_zero, fast_loop_gain;
	logic        reg_hit, switching_frequency, period_start, sync_in;
	int          n_errors = 0, num_checks = 0, on_width, cycles = 0;
	logic [15:0] adr[5] = '{16'hfe1d, 16'hfe1e, 16'hfe20, 16'hfe21, 16'hfe22};
	logic [7:0]  dat[5] = '{8'hff, 8'hfe, 8'ha5, 8'h5a, 8'hc3};
	pfc_switching_freq_loop_config pfc_switching_freq_loop_config_inst (.*);
	pfc_sync_source pfc_sync_source_inst (.*);
	initial forever #50 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	// 64 bits wide so that a packed {min, max} pair is compared whole
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk) #1;
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1;
		@(posedge core_clk) #1 reg_write = 0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic hit);
		@(posedge core_clk) #1;
		reg_addr = a;
		reg_read = 1;
		@(posedge core_clk) #1 reg_read = 0;
		check(reg_rdata, exp);
		check(reg_hit, hit);
	endtask
	// shortest and longest spacing of period starts over n cycles
	task automatic meas(input int n, output int mn, output int mx);
		int last;
		last = -1;
		mn = 999;
		mx = 0;
		for (int c = 0; c < n; c++) begin
			@(posedge core_clk) #1;
			if (period_start === 1'b1) begin
				if (last >= 0 && c - last < mn) mn = c - last;
				if (last >= 0 && c - last > mx) mx = c - last;
				last = c;
			end
		end
	endtask
	task automatic t_regs;
		foreach (adr[i]) rd(adr[i], 8'h00, 1'b1);
		foreach (adr[i]) wr(adr[i], dat[i]);
		wr(16'hfe1f, 8'h77);
		foreach (adr[i]) rd(adr[i], dat[i] & (i == 0 ? 8'h7f : 8'hff), 1'b1);
		rd(16'hfe1f, 8'h00, 1'b0);
		check({normal_loop_gain, normal_loop_zero, fast_loop_gain}, 24'ha55ac3);
	endtask
	task automatic t_sync;
		int n;
		ext_sync_enable = 1;
		run = 1;
		for (int d = 0; d < 4; d++) begin
			wr(16'hfe1e, 8'(d));
			repeat (40) @(posedge core_clk);
			n = 0;
			repeat (240) begin
				@(posedge core_clk) #1;
				if (period_start === 1'b1) n++;
			end
			check(n, 12 / (d + 1));
			check(on_width, 5);
		end
		run = 0;
		ext_sync_enable = 0;
	endtask
	task automatic t_dither;
		int mn, mx;
		meas(600, mn, mx);
		check({mn, mx}, {32'd100, 32'd100});
		wr(16'hfe1d, 8'h04);
		dither_enable = 1;
		// four counts of 400 cycles: no step before 1600 cycles, then one step
		meas(1500, mn, mx);
		check({mn, mx}, {32'd100, 32'd100});
		meas(400, mn, mx);
		check({mn, mx}, {32'd100, 32'd101});
		wr(16'hfe1d, 8'h01);
		meas(4000, mn, mx);
		check({mn, mx}, {32'd100, 32'd104});
		dither_enable = 0;
	endtask
	task automatic t_code;
		int mn, mx;
		logic [5:0] codes[4] = '{6'h3f, 6'h3e, 6'h18, 6'h20};
		int per[4] = '{25, 25, 67, 49};
		smart_freq_enable = 1;
		low_power = 1;
		foreach (codes[i]) begin
			low_power_freq_code = codes[i];
			meas(250, mn, mx);
			meas(300, mn, mx);
			check({mn, mx}, {per[i], per[i]});
		end
		low_power = 0;
		meas(250, mn, mx);
		meas(400, mn, mx);
		check({mn, mx}, {32'd100, 32'd100});
		smart_freq_enable = 0;
		low_power = 1;
		meas(250, mn, mx);
		meas(400, mn, mx);
		check({mn, mx}, {32'd100, 32'd100});
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		#1 rst_n = 1;
		t_regs();
		t_sync();
		t_dither();
		t_code();
		finish_test();
	end
endmodule
`default_nettype wire
